// File: logic/stam_consts.vh
// constants of the torque-arrival status monitor: object indices, bits, modes
// assumes nothing; included by bare name from the design files
`ifndef STAM_CONSTS_VH
`define STAM_CONSTS_VH
// ************************************************
// object indices and sub-indices
// ************************************************
`define STAM_IDX_ARRIVAL 16'h2015
`define STAM_SUB_REF 8'h11
`define STAM_SUB_SET 8'h12
`define STAM_SUB_CLR 8'h13
`define STAM_IDX_FAULT 16'h603f
`define STAM_IDX_CMD 16'h6040
`define STAM_IDX_STATUS 16'h6041
`define STAM_IDX_MODE 16'h6061
`define STAM_IDX_VEL 16'h606c
`define STAM_IDX_TQDEM 16'h6074
`define STAM_IDX_TQMEAS 16'h6077
`define STAM_IDX_SPDCEIL 16'h607f
// ************************************************
// status word bits and reset values
// ************************************************
`define STAM_BIT_TQ_REACHED 10
`define STAM_BIT_FOLLOW 12
`define STAM_BIT_HOMED 15
`define STAM_STATUS_RESET 16'h0000
`define STAM_WORD16_RESET 16'h0000
`define STAM_WORD32_RESET 32'h0000_0000
// ************************************************
// operating modes
// ************************************************
`define STAM_MODE_PP 8'h01
`define STAM_MODE_CST 8'h0a
// ************************************************
// timing: position loop period in ns and its cycle count at 25 MHz
// ************************************************
`define STAM_CLK_PERIOD_NS 40
`define STAM_PLOOP_NS 250000
`define STAM_PLOOP_CYCLES (`STAM_PLOOP_NS / `STAM_CLK_PERIOD_NS)
`define STAM_PLOOP_LAST 14'd6249
`endif

// File: logic/stam_hyst.v
// hysteresis comparator for the torque-arrival flag
// assumes signed 0.1 % torque inputs, thresholds unsigned 0..3000
`timescale 1ns/100ps
`default_nettype none
module stam_hyst (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire signed [15:0] torque_i,
  input wire [15:0] ref_i,
  input wire [15:0] set_thr_i,
  input wire [15:0] clr_thr_i,
  output reg reached_o
);
  // ************************************************
  // difference magnitude
  // ************************************************
  wire signed [17:0] diff; // torque minus reference
  wire [17:0] diff_abs; // magnitude of difference
  assign diff = {{2{torque_i[15]}}, torque_i} - $signed({2'b00, ref_i});
  assign diff_abs = diff[17] ? (~diff + 18'h00001) : diff;
  // ************************************************
  // flag update with hold band
  // ************************************************
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      reached_o <= 1'b0;
    end else if (diff_abs > {2'b00, set_thr_i}) begin
      reached_o <= 1'b1;
    end else if (diff_abs < {2'b00, clr_thr_i}) begin
      reached_o <= 1'b0;
    end
    // otherwise hold previous state
  end
endmodule
`default_nettype wire

// File: logic/stam_top.v
// status monitor of a servo drive: torque arrival, status word, speed limit,
// cyclic feedback, profile-position target discard on mode change
// assumes a synchronous object access port driven by the fieldbus slave logic
// Contract
// - status bit 10 shows torque reached
// - status bit 12 shows following master
// - status bit 15 shows homing complete
// - difference above set threshold sets flag
// - difference below clear threshold clears flag
// - cyclic torque speed limit is minimum
// - cyclic torque mode publishes feedback objects
// - leaving position mode drops pending targets
// - drive plans trajectory from profile values; this block only hands the pending target out on pp_target_o
`timescale 1ns/100ps
`default_nettype none
`include "stam_consts.vh"
module stam_top (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire obj_wr_i,
  input wire obj_rd_i,
  input wire [15:0] obj_index_i,
  input wire [7:0] obj_sub_i,
  input wire [31:0] obj_wdata_i,
  output reg [31:0] obj_rdata_o,
  output reg obj_rvalid_o,
  output reg obj_err_o,
  input wire [7:0] mode_i,
  input wire [15:0] fault_i,
  input wire signed [31:0] velocity_i,
  input wire signed [15:0] torque_demand_i,
  input wire signed [15:0] torque_meas_i,
  input wire [31:0] motor_max_speed_i,
  input wire following_i,
  input wire homed_i,
  input wire pp_target_load_i,
  input wire [31:0] pp_target_i,
  input wire pp_target_take_i,
  output reg pp_target_valid_o,
  output reg [31:0] pp_target_o,
  output wire ploop_tick_o,
  output reg [31:0] speed_limit_o,
  output reg speed_limit_en_o,
  output wire torque_reached_output_o,
  output reg [15:0] status_word_o,
  output reg cyc_valid_o,
  output reg [15:0] cyc_command_o,
  output reg [15:0] cyc_fault_o,
  output reg [15:0] cyc_status_o,
  output reg [7:0] cyc_mode_o,
  output reg [31:0] cyc_velocity_o,
  output reg [15:0] cyc_tq_demand_o,
  output reg [15:0] cyc_tq_meas_o
);
  // ************************************************
  // writable objects and internal state
  // ************************************************
  reg [15:0] torque_arrival_reference; // arrival reference, 0.1 %
  reg [15:0] torque_arrival_set_threshold; // set level
  reg [15:0] torque_arrival_clear_threshold; // clear level
  reg [15:0] command_word; // master command word
  reg [31:0] speed_ceiling; // configured maximum speed
  reg [7:0] mode_prev; // mode of last cycle
  reg [13:0] ploop_cnt; // position-loop divider
  wire reached; // hysteresis flag
  wire in_cst; // cyclic torque active
  wire left_pp; // position mode just left
  wire is_arr; // arrival object index hit
  assign in_cst = (mode_i == `STAM_MODE_CST);
  assign left_pp = (mode_prev == `STAM_MODE_PP) && (mode_i != `STAM_MODE_PP);
  assign is_arr = (obj_index_i == `STAM_IDX_ARRIVAL);
  assign torque_reached_output_o = reached;
  assign ploop_tick_o = (ploop_cnt == 14'd0);
  // ************************************************
  // torque arrival comparator
  // ************************************************
  stam_hyst u_hyst (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .torque_i(torque_meas_i),
    .ref_i(torque_arrival_reference),
    .set_thr_i(torque_arrival_set_threshold),
    .clr_thr_i(torque_arrival_clear_threshold),
    .reached_o(reached)
  );
  // ************************************************
  // object writes
  // ************************************************
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      torque_arrival_reference <= `STAM_WORD16_RESET;
      torque_arrival_set_threshold <= `STAM_WORD16_RESET;
      torque_arrival_clear_threshold <= `STAM_WORD16_RESET;
      command_word <= `STAM_WORD16_RESET;
      speed_ceiling <= `STAM_WORD32_RESET;
    end else if (obj_wr_i) begin
      // unknown or read-only objects ignore writes
      if (is_arr && obj_sub_i == `STAM_SUB_REF) begin
        torque_arrival_reference <= obj_wdata_i[15:0];
      end
      if (is_arr && obj_sub_i == `STAM_SUB_SET) begin
        torque_arrival_set_threshold <= obj_wdata_i[15:0];
      end
      if (is_arr && obj_sub_i == `STAM_SUB_CLR) begin
        torque_arrival_clear_threshold <= obj_wdata_i[15:0];
      end
      if (obj_index_i == `STAM_IDX_CMD) begin
        command_word <= obj_wdata_i[15:0];
      end
      if (obj_index_i == `STAM_IDX_SPDCEIL) begin
        speed_ceiling <= obj_wdata_i;
      end
    end
  end
  // ************************************************
  // status word, speed limit, cyclic feedback
  // ************************************************
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      status_word_o <= `STAM_STATUS_RESET;
      speed_limit_o <= `STAM_WORD32_RESET;
      speed_limit_en_o <= 1'b0;
      cyc_valid_o <= 1'b0;
      cyc_command_o <= `STAM_WORD16_RESET;
      cyc_fault_o <= `STAM_WORD16_RESET;
      cyc_status_o <= `STAM_WORD16_RESET;
      cyc_mode_o <= 8'h00;
      cyc_velocity_o <= `STAM_WORD32_RESET;
      cyc_tq_demand_o <= `STAM_WORD16_RESET;
      cyc_tq_meas_o <= `STAM_WORD16_RESET;
      mode_prev <= 8'h00;
    end else begin
      mode_prev <= mode_i;
      status_word_o <= `STAM_STATUS_RESET;
      status_word_o[`STAM_BIT_TQ_REACHED] <= reached;
      status_word_o[`STAM_BIT_FOLLOW] <= following_i;
      status_word_o[`STAM_BIT_HOMED] <= homed_i;
      // smaller of configured and motor maximum
      speed_limit_o <= (speed_ceiling < motor_max_speed_i) ? speed_ceiling : motor_max_speed_i;
      speed_limit_en_o <= in_cst;
      // feedback snapshot each clock while in cyclic torque
      cyc_valid_o <= in_cst;
      if (in_cst) begin
        cyc_command_o <= command_word;
        cyc_fault_o <= fault_i;
        cyc_status_o <= status_word_o;
        cyc_mode_o <= mode_i;
        cyc_velocity_o <= velocity_i;
        cyc_tq_demand_o <= torque_demand_i;
        cyc_tq_meas_o <= torque_meas_i;
      end
    end
  end
  // ************************************************
  // position-loop tick divider (250 us)
  // ************************************************
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ploop_cnt <= 14'd0;
    end else if (ploop_cnt == `STAM_PLOOP_LAST) begin
      ploop_cnt <= 14'd0;
    end else begin
      ploop_cnt <= ploop_cnt + 14'd1;
    end
  end
  // ************************************************
  // pending position target, handed to the planner
  // ************************************************
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pp_target_valid_o <= 1'b0;
      pp_target_o <= `STAM_WORD32_RESET;
    end else if (left_pp || mode_i != `STAM_MODE_PP) begin
      pp_target_valid_o <= 1'b0;
    end else if (pp_target_load_i) begin
      // planner builds the trajectory from this target
      pp_target_valid_o <= 1'b1;
      pp_target_o <= pp_target_i;
    end else if (pp_target_take_i) begin
      pp_target_valid_o <= 1'b0;
    end
  end
  // ************************************************
  // object reads, one cycle latency
  // ************************************************
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      obj_rdata_o <= `STAM_WORD32_RESET;
      obj_rvalid_o <= 1'b0;
      obj_err_o <= 1'b0;
    end else begin
      obj_rvalid_o <= obj_rd_i;
      obj_err_o <= 1'b0;
      obj_rdata_o <= `STAM_WORD32_RESET;
      if (obj_rd_i) begin
        case (obj_index_i)
          `STAM_IDX_ARRIVAL: begin
            if (obj_sub_i == `STAM_SUB_REF) begin
              obj_rdata_o <= {16'h0000, torque_arrival_reference};
            end else if (obj_sub_i == `STAM_SUB_SET) begin
              obj_rdata_o <= {16'h0000, torque_arrival_set_threshold};
            end else if (obj_sub_i == `STAM_SUB_CLR) begin
              obj_rdata_o <= {16'h0000, torque_arrival_clear_threshold};
            end else begin
              obj_err_o <= 1'b1;
            end
          end
          `STAM_IDX_FAULT: obj_rdata_o <= {16'h0000, fault_i};
          `STAM_IDX_CMD: obj_rdata_o <= {16'h0000, command_word};
          `STAM_IDX_STATUS: obj_rdata_o <= {16'h0000, status_word_o};
          `STAM_IDX_MODE: obj_rdata_o <= {24'h000000, mode_i};
          `STAM_IDX_VEL: obj_rdata_o <= velocity_i;
          `STAM_IDX_TQDEM: obj_rdata_o <= {{16{torque_demand_i[15]}}, torque_demand_i};
          `STAM_IDX_TQMEAS: obj_rdata_o <= {{16{torque_meas_i[15]}}, torque_meas_i};
          `STAM_IDX_SPDCEIL: obj_rdata_o <= speed_ceiling;
          default: obj_err_o <= 1'b1;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: test/stam_top_props.sv
// assertions on the torque-arrival status monitor ports
// assumes it is bound to stam_top and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module stam_props (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic obj_wr_i,
  input wire logic [15:0] obj_index_i,
  input wire logic [7:0] obj_sub_i,
  input wire logic [31:0] obj_wdata_i,
  input wire logic [7:0] mode_i,
  input wire logic signed [15:0] torque_meas_i,
  input wire logic [31:0] motor_max_speed_i,
  input wire logic following_i,
  input wire logic homed_i,
  input wire logic pp_target_load_i,
  input wire logic [31:0] pp_target_i,
  input wire logic pp_target_valid_o,
  input wire logic [31:0] pp_target_o,
  input wire logic [31:0] speed_limit_o,
  input wire logic torque_reached_output_o,
  input wire logic [15:0] status_word_o,
  input wire logic [15:0] cyc_tq_meas_o
);
  logic [15:0] rf, st, cl; // shadow reference and thresholds
  int ad; // distance of torque from reference
  logic [31:0] sc, lim_exp; // shadow ceiling and expected speed limit
  always_comb ad = (int'(torque_meas_i) < int'(rf)) ?
    int'(rf) - int'(torque_meas_i) : int'(torque_meas_i) - int'(rf);
  // shadow copies follow the object writes
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rf <= 16'h0000;
      st <= 16'h0000;
      cl <= 16'h0000;
    end else if (obj_wr_i && obj_index_i == 16'h2015) begin
      if (obj_sub_i == 8'h11) rf <= obj_wdata_i[15:0];
      if (obj_sub_i == 8'h12) st <= obj_wdata_i[15:0];
      if (obj_sub_i == 8'h13) cl <= obj_wdata_i[15:0];
    end
  end
  // shadow of the configured speed ceiling
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sc <= 32'h0000_0000;
    end else if (obj_wr_i && obj_index_i == 16'h607f) begin
      sc <= obj_wdata_i;
    end
  end
  // smaller of configured and motor maximum
  always_comb lim_exp = (sc < motor_max_speed_i) ? sc : motor_max_speed_i;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  chk_flag_set: assert property (ad > int'(st) |=> torque_reached_output_o)
    else $error("flag not set");
  chk_flag_clear: assert property (ad < int'(cl) && ad <= int'(st) |=> !torque_reached_output_o)
    else $error("flag not cleared");
  chk_flag_hold: assert property (ad <= int'(st) && ad >= int'(cl) |=> $stable(torque_reached_output_o))
    else $error("flag moved between thresholds");
  chk_status_flag: assert property ($past(resetn_i) |-> status_word_o[10] == $past(torque_reached_output_o))
    else $error("status bit 10 differs from flag");
  chk_status_follow: assert property ($past(resetn_i) |-> status_word_o[12] == $past(following_i))
    else $error("status bit 12 wrong");
  chk_status_homed: assert property ($past(resetn_i) |-> status_word_o[15] == $past(homed_i))
    else $error("status bit 15 wrong");
  chk_speed_below_max: assert property ($past(resetn_i) && $stable(motor_max_speed_i)
    |-> speed_limit_o <= motor_max_speed_i)
    else $error("speed limit above motor maximum");
  chk_speed_is_min: assert property ($past(resetn_i) |-> speed_limit_o == $past(lim_exp))
    else $error("speed limit not the smaller maximum");
  chk_cyc_torque: assert property (mode_i == 8'h0a |=> cyc_tq_meas_o == $past(torque_meas_i))
    else $error("cyclic torque not refreshed");
  chk_pp_drop: assert property (pp_target_valid_o && mode_i != 8'h01 |=> !pp_target_valid_o)
    else $error("pending target kept after mode change");
  chk_pp_load: assert property (pp_target_load_i && mode_i == 8'h01
    |=> pp_target_valid_o && pp_target_o == $past(pp_target_i))
    else $error("target not taken for planning");
endmodule
bind stam_top stam_props u_props (.clk_sys_i, .resetn_i, .obj_wr_i, .obj_index_i, .obj_sub_i, .obj_wdata_i,
  .mode_i, .torque_meas_i, .motor_max_speed_i, .following_i, .homed_i, .pp_target_load_i, .pp_target_i,
  .pp_target_valid_o, .pp_target_o, .speed_limit_o, .torque_reached_output_o, .status_word_o, .cyc_tq_meas_o);
`default_nettype wire

// File: test/stam_master.sv
// fieldbus master model: object writes and reads
// assumes callers enter its tasks at a falling clock edge
`timescale 1ns/100ps
`default_nettype none
module stam_master (
  input wire logic clk_sys_i,
  output logic obj_wr_o,
  output logic obj_rd_o,
  output logic [15:0] obj_index_o,
  output logic [7:0] obj_sub_o,
  output logic [31:0] obj_wdata_o,
  input wire logic [31:0] obj_rdata_i,
  input wire logic obj_rvalid_i,
  input wire logic obj_err_i
);
  localparam int CYC_CLKS = 25000; // cycle of 1 ms at 40 ns, four loop periods
  initial begin
    obj_wr_o = 1'b0;
    obj_rd_o = 1'b0;
    obj_index_o = 16'h0000;
    obj_sub_o = 8'h00;
    obj_wdata_o = 32'h0000_0000;
  end
  // one-cycle write strobe, data inverted once released
  task automatic put(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] v);
    obj_wr_o = 1'b1;
    obj_index_o = ix;
    obj_sub_o = sb;
    obj_wdata_o = v;
    @(negedge clk_sys_i);
    obj_wr_o = 1'b0;
    obj_wdata_o = ~v;
    @(negedge clk_sys_i);
  endtask
  // wait one full master cycle before the next set-point
  task automatic next_cycle();
    repeat (CYC_CLKS) @(negedge clk_sys_i);
  endtask
  // read strobe, answer taken the cycle after
  task automatic get(input logic [15:0] ix, input logic [7:0] sb, output logic [31:0] v, output logic [31:0] f);
    obj_rd_o = 1'b1;
    obj_index_o = ix;
    obj_sub_o = sb;
    @(negedge clk_sys_i);
    obj_rd_o = 1'b0;
    v = obj_rdata_i;
    f = {30'h0, obj_rvalid_i, obj_err_i};
    @(negedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

// File: test/test_stam_top.sv
// testbench of the status monitor, master model on the object bus
// assumes the design answers reads one cycle after the strobe
`timescale 1ns/100ps
`default_nettype none
module test_stam_top;
  logic clk_sys_i = 1'b0, resetn_i = 1'b0, following_i = 1'b0, homed_i = 1'b0;
  logic pp_target_load_i = 1'b0, pp_target_take_i = 1'b0;
  logic [7:0] mode_i = 8'h00;
  logic [15:0] fault_i = 16'h0000, torque_demand_i = 16'h0000, torque_meas_i = 16'h0000;
  logic [31:0] velocity_i = 32'h0, motor_max_speed_i = 32'h0, pp_target_i = 32'h0;
  logic wr, rd, rvalid, err, pp_valid, tq_flag, cyc_valid, lim_en, tick;
  logic [15:0] index, status, cyc_cmd, cyc_fault, cyc_dem, cyc_meas, cyc_stat;
  logic [7:0] sub, cyc_mode;
  logic [31:0] wdata, rdata, pp_target, speed_limit, cyc_vel;
  int miscompares = 0, checks_done = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  stam_master mst (.clk_sys_i, .obj_wr_o(wr), .obj_rd_o(rd), .obj_index_o(index), .obj_sub_o(sub),
    .obj_wdata_o(wdata), .obj_rdata_i(rdata), .obj_rvalid_i(rvalid), .obj_err_i(err));
  stam_top uut (.clk_sys_i, .resetn_i, .obj_wr_i(wr), .obj_rd_i(rd), .obj_index_i(index), .obj_sub_i(sub),
    .obj_wdata_i(wdata), .obj_rdata_o(rdata), .obj_rvalid_o(rvalid), .obj_err_o(err), .mode_i, .fault_i,
    .velocity_i, .torque_demand_i, .torque_meas_i, .motor_max_speed_i, .following_i, .homed_i,
    .pp_target_load_i, .pp_target_i, .pp_target_take_i, .pp_target_valid_o(pp_valid), .pp_target_o(pp_target),
    .ploop_tick_o(tick), .speed_limit_o(speed_limit), .speed_limit_en_o(lim_en), .torque_reached_output_o(tq_flag),
    .status_word_o(status), .cyc_valid_o(cyc_valid), .cyc_command_o(cyc_cmd), .cyc_fault_o(cyc_fault),
    .cyc_status_o(cyc_stat), .cyc_mode_o(cyc_mode), .cyc_velocity_o(cyc_vel), .cyc_tq_demand_o(cyc_dem),
    .cyc_tq_meas_o(cyc_meas));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // torque step, flag and status bit checked two cycles on
  task automatic tq(input logic [15:0] t, input logic f);
    torque_meas_i = t;
    repeat (2) @(negedge clk_sys_i);
    check({31'h0, tq_flag}, {31'h0, f});
    check({31'h0, status[10]}, {31'h0, f});
  endtask
  task automatic t_regs();
    logic [31:0] v, f;
    mst.get(16'h6041, 8'h00, v, f);
    check(v, 32'h0);
    fault_i = 16'h1234;
    mst.put(16'h603f, 8'h00, 32'h0);
    mst.get(16'h603f, 8'h00, v, f);
    check(v, 32'h1234);
    mst.get(16'h2015, 8'h14, v, f);
    check(f, 32'h3);
    mst.put(16'h607f, 8'h00, 32'h500);
    mst.put(16'h6040, 8'h00, 32'h000f);
    mst.get(16'h607f, 8'h00, v, f);
    check(v, 32'h500);
  endtask
  task automatic t_flag();
    mst.put(16'h2015, 8'h11, 32'd100);
    mst.put(16'h2015, 8'h12, 32'd50);
    mst.put(16'h2015, 8'h13, 32'd20);
    tq(16'd151, 1'b1);
    tq(16'd120, 1'b1);
    tq(16'd119, 1'b0);
    tq(16'd150, 1'b0);
    tq(16'd49, 1'b1);
  endtask
  task automatic t_status();
    following_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    check({16'h0, status & 16'h9000}, 32'h1000);
    following_i = 1'b0;
    homed_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    check({16'h0, status & 16'h9000}, 32'h8000);
  endtask
  task automatic t_cst();
    logic [31:0] v, f;
    mode_i = 8'h0a;
    motor_max_speed_i = 32'h400;
    velocity_i = 32'hffff_fffb;
    torque_demand_i = 16'hec78;
    repeat (2) @(negedge clk_sys_i);
    check(speed_limit, 32'h400);
    check({31'h0, lim_en}, 32'h1);
    check({cyc_dem, cyc_meas}, 32'hec78_0031);
    check({cyc_cmd, cyc_fault}, 32'h000f_1234);
    check(cyc_vel, 32'hffff_fffb);
    check({23'h0, cyc_valid, cyc_mode}, 32'h10a);
    check({16'h0, cyc_stat}, 32'h8400);
    motor_max_speed_i = 32'h600;
    repeat (2) @(negedge clk_sys_i);
    check(speed_limit, 32'h500);
    mst.get(16'h6074, 8'h00, v, f);
    check(v, 32'hffff_ec78);
    check(f, 32'h2);
  endtask
  // position-loop tick spacing, 250 us at 40 ns
  task automatic t_tick();
    int n;
    while (!tick) @(negedge clk_sys_i);
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (!tick);
    check(n, 32'd6250);
  endtask
  task automatic t_pp();
    mode_i = 8'h01;
    pp_target_i = 32'h1000;
    pp_target_load_i = 1'b1;
    @(negedge clk_sys_i);
    pp_target_load_i = 1'b0;
    pp_target_take_i = 1'b1;
    check({pp_valid, pp_target[30:0]}, 32'h8000_1000);
    @(negedge clk_sys_i);
    pp_target_take_i = 1'b0;
    check({31'h0, pp_valid}, 32'h0);
    mst.next_cycle();
    pp_target_load_i = 1'b1;
    @(negedge clk_sys_i);
    pp_target_load_i = 1'b0;
    check({31'h0, pp_valid}, 32'h1);
    mode_i = 8'h0a;
    @(negedge clk_sys_i);
    pp_target_load_i = 1'b1;
    check({31'h0, pp_valid}, 32'h0);
    @(negedge clk_sys_i);
    pp_target_load_i = 1'b0;
    check({31'h0, pp_valid}, 32'h0);
  endtask
  initial begin
    repeat (20) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    @(negedge clk_sys_i);
    t_regs();
    t_flag();
    t_status();
    t_cst();
    t_tick();
    t_pp();
    tally_and_finish();
  end
  // watchdog at 50000 cycles, beyond the roughly 38000 the tests need
  initial begin
    #2000000;
    miscompares++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
